/* rtl/bcfu_top.sv */
// Summary of operation
// - Signed greater: N equals V and Z clear
// - Unsigned higher: C or Z equals zero
// - Higher-or-same and carry-clear share one code
// - Bit test: AND, set N Z, clear V
// - Signed at most: Z or N xor V
// - Unsigned lower and carry-set share one code
// - Unsigned at most: C or Z set
// - Signed less: exactly one of N, V
// - Minus jump taken when N set
// - Not equal jump taken when Z clear
// - Plus jump taken when N clear
// - Unconditional jump loads PC plus offset
// - Never jump consumes offset, no branch
// - Call pushes PC low, then high, jumps
// - No overflow jump taken when V clear
// - Overflow jump taken when V set
// - Clear writes zero, N V C clear, Z set
// - Memory clear reads address before writing
// - 8-bit compare sets flags, stores nothing
// - Compare carry is inverted subtraction carry
// - 16-bit compare sets flags, H unchanged
//
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "bcfu_regs.svh"
module bcfu_top (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                reset,
    // Sequencer request
    input  wire logic                req_valid_i,
    input  wire bcfu_pkg::bcfu_req_s req_i,
    output logic                     req_ready_o,
    // Result
    output logic                     done_o,
    output var bcfu_pkg::bcfu_res_s  res_o,
    // Memory and stack path
    output var bcfu_pkg::bcfu_mem_s  mem_o,
    input  wire logic                mem_ack_i,
    // Wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [3:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic [31:0]              wb_dat_o,
    output logic                     wb_ack_o
);

    bcfu_pkg::bcfu_state_s s_reg;
    bcfu_pkg::bcfu_state_s s_next;
    logic                  take;
    logic                  wr;
    logic                  inc;
    logic [7:0]            and_res;
    logic [8:0]            d8;
    logic [16:0]           d16;
    logic [15:0]           tgt_now;
    logic [15:0]           tgt_held;

    function automatic logic [15:0] sext(input logic lng, input logic [15:0] o);
        sext = lng ? o : {{8{o[7]}}, o[7:0]};
    endfunction

    function automatic logic cond_met(input logic [3:0] c, input logic [7:0] f);
        logic n;
        logic z;
        logic v;
        logic cy;
        n = f[`BCFU_CC_N];
        z = f[`BCFU_CC_Z];
        v = f[`BCFU_CC_V];
        cy = f[`BCFU_CC_C];
        case (c)
            `BCFU_J_ALWAYS: cond_met = 1'b1;
            `BCFU_J_NEVER:  cond_met = 1'b0;
            `BCFU_J_HI:     cond_met = (cy | z) == 1'b0;
            `BCFU_J_LS:     cond_met = (cy | z) == 1'b1;
            `BCFU_J_CARRY0: cond_met = !cy;
            `BCFU_J_CARRY1: cond_met = cy;
            `BCFU_J_NE:     cond_met = !z;
            `BCFU_J_EQ:     cond_met = z;
            `BCFU_J_OVF0:   cond_met = !v;
            `BCFU_J_OVF1:   cond_met = v;
            `BCFU_J_PLUS:   cond_met = !n;
            `BCFU_J_MINUS:  cond_met = n;
            `BCFU_J_GE:     cond_met = (n ^ v) == 1'b0;
            `BCFU_J_LT:     cond_met = (n ^ v) == 1'b1;
            `BCFU_J_GT:     cond_met = (n == v) && !z;
            `BCFU_J_LE:     cond_met = z || ((n ^ v) == 1'b1);
            default:        cond_met = 1'b0;
        endcase
    endfunction

    assign req_ready_o = (s_reg.st == bcfu_pkg::ST_IDLE) && s_reg.en;
    assign take        = req_valid_i && req_ready_o;
    assign done_o      = s_reg.done;
    assign res_o       = s_reg.res;
    assign mem_o       = s_reg.mem;
    assign wb_ack_o    = s_reg.ack;
    assign wb_dat_o    = s_reg.dat;

    assign d8       = {1'b0, req_i.acc[7:0]} + {1'b0, ~req_i.mem[7:0]} + 9'h001;
    assign d16      = {1'b0, req_i.acc} + {1'b0, ~req_i.mem} + 17'h00001;
    assign and_res  = req_i.acc[7:0] & req_i.mem[7:0];
    assign tgt_now  = req_i.pc + sext(req_i.long_off, req_i.offset);
    assign tgt_held = s_reg.req.pc + sext(s_reg.req.long_off, s_reg.req.offset);

    always_comb
    begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;
        wr = wb_cyc_i && wb_stb_i && wb_we_i && s_reg.ack;
        if (s_next.ack)
        begin
            s_next.dat = 32'h0000_0000;
            case (wb_adr_i)
                `BCFU_OFS_CTRL:
                    s_next.dat[`BCFU_CTRL_EN] = s_reg.en;
                `BCFU_OFS_STATUS:
                begin
                    s_next.dat[`BCFU_ST_BUSY] = s_reg.st != bcfu_pkg::ST_IDLE;
                    s_next.dat[`BCFU_ST_TAKEN] = s_reg.res.taken;
                    s_next.dat[`BCFU_ST_CC_MSB:`BCFU_ST_CC_LSB] = s_reg.res.cc;
                end
                `BCFU_OFS_COUNT:
                    s_next.dat[15:0] = s_reg.cnt;
                default:
                    s_next.dat = 32'h0000_0000;
            endcase
        end
        if (wr && wb_adr_i == `BCFU_OFS_CTRL && wb_sel_i[0])
            s_next.en = wb_dat_i[`BCFU_CTRL_EN];
        case (s_reg.st)
            bcfu_pkg::ST_IDLE:
                if (take)
                begin
                    s_next.req = req_i;
                    s_next.res.cc = req_i.cc;
                    s_next.res.pc = req_i.pc;
                    s_next.res.sp = req_i.sp;
                    s_next.res.data = `BCFU_ZERO8;
                    s_next.res.acc_we = 1'b0;
                    s_next.res.taken = 1'b0;
                    s_next.done = 1'b1;
                    case (req_i.op)
                        bcfu_pkg::OP_JUMP:
                        begin
                            s_next.res.taken = cond_met(req_i.cond, req_i.cc);
                            if (s_next.res.taken)
                                s_next.res.pc = tgt_now;
                        end
                        bcfu_pkg::OP_CALL:
                        begin
                            s_next.done = 1'b0;
                            s_next.st = bcfu_pkg::ST_PUSH_LO;
                            s_next.mem.valid = 1'b1;
                            s_next.mem.we = 1'b1;
                            s_next.mem.addr = req_i.sp - `BCFU_STEP;
                            s_next.mem.wdata = req_i.pc[7:0];
                        end
                        bcfu_pkg::OP_BITTEST:
                        begin
                            s_next.res.cc[`BCFU_CC_N] = and_res[7];
                            s_next.res.cc[`BCFU_CC_Z] = and_res == `BCFU_ZERO8;
                            s_next.res.cc[`BCFU_CC_V] = 1'b0;
                        end
                        bcfu_pkg::OP_CLR_ACC, bcfu_pkg::OP_CLR_MEM:
                        begin
                            s_next.res.cc[`BCFU_CC_N] = 1'b0;
                            s_next.res.cc[`BCFU_CC_Z] = 1'b1;
                            s_next.res.cc[`BCFU_CC_V] = 1'b0;
                            s_next.res.cc[`BCFU_CC_C] = 1'b0;
                            s_next.res.acc_we = req_i.op == bcfu_pkg::OP_CLR_ACC;
                            if (req_i.op == bcfu_pkg::OP_CLR_MEM)
                            begin
                                s_next.done = 1'b0;
                                s_next.st = bcfu_pkg::ST_CLR_RD;
                                s_next.mem.valid = 1'b1;
                                s_next.mem.we = 1'b0;
                                s_next.mem.addr = req_i.ea;
                                s_next.mem.wdata = `BCFU_ZERO8;
                            end
                        end
                        bcfu_pkg::OP_CMP8:
                        begin
                            s_next.res.cc[`BCFU_CC_N] = d8[7];
                            s_next.res.cc[`BCFU_CC_Z] = d8[7:0] == `BCFU_ZERO8;
                            s_next.res.cc[`BCFU_CC_V] = (req_i.acc[7] ^ req_i.mem[7])
                                                       & (req_i.acc[7] ^ d8[7]);
                            s_next.res.cc[`BCFU_CC_C] = !d8[8];
                        end
                        bcfu_pkg::OP_CMP16:
                        begin
                            s_next.res.cc[`BCFU_CC_N] = d16[15];
                            s_next.res.cc[`BCFU_CC_Z] = d16[15:0] == 16'h0000;
                            s_next.res.cc[`BCFU_CC_V] = (req_i.acc[15] ^ req_i.mem[15])
                                                       & (req_i.acc[15] ^ d16[15]);
                            s_next.res.cc[`BCFU_CC_C] = !d16[16];
                        end
                        default:
                            s_next.done = 1'b1;
                    endcase
                end
            bcfu_pkg::ST_CLR_RD:
                if (mem_ack_i)
                begin
                    s_next.mem.we = 1'b1;
                    s_next.st = bcfu_pkg::ST_CLR_WR;
                end
            bcfu_pkg::ST_CLR_WR:
                if (mem_ack_i)
                begin
                    s_next.mem.valid = 1'b0;
                    s_next.st = bcfu_pkg::ST_IDLE;
                    s_next.done = 1'b1;
                end
            bcfu_pkg::ST_PUSH_LO:
                if (mem_ack_i)
                begin
                    s_next.mem.addr = s_reg.mem.addr - `BCFU_STEP;
                    s_next.mem.wdata = s_reg.req.pc[15:8];
                    s_next.st = bcfu_pkg::ST_PUSH_HI;
                end
            bcfu_pkg::ST_PUSH_HI:
                if (mem_ack_i)
                begin
                    s_next.mem.valid = 1'b0;
                    s_next.st = bcfu_pkg::ST_IDLE;
                    s_next.done = 1'b1;
                    s_next.res.taken = 1'b1;
                    s_next.res.pc = tgt_held;
                    s_next.res.sp = s_reg.mem.addr;
                end
            default:
                s_next.st = bcfu_pkg::ST_IDLE;
        endcase
        inc = s_next.done && s_next.res.taken;
        // A clear in the same cycle as an increment loads the count with 1
        if (wr && wb_adr_i == `BCFU_OFS_COUNT && wb_sel_i[0])
            s_next.cnt = {15'h0000, inc};
        else
            s_next.cnt = s_reg.cnt + {15'h0000, inc};
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_reg <= '0;
            s_reg.st <= bcfu_pkg::ST_IDLE;
            s_reg.en <= `BCFU_CTRL_RST;
        end
        else
            s_reg <= s_next;
    end

    // Checks on finished operations and on clear and call memory sequences
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic       jd;
    logic [7:0] qf;
    logic [3:0] qc;
    assign jd = done_o && s_reg.req.op == bcfu_pkg::OP_JUMP;
    assign qf = s_reg.req.cc;
    assign qc = s_reg.req.cond;

    sequence s_clr_rd;
        s_reg.st == bcfu_pkg::ST_CLR_RD && mem_ack_i;
    endsequence
    sequence s_lo_ack;
        s_reg.st == bcfu_pkg::ST_PUSH_LO && mem_ack_i;
    endsequence

    a_gt_taken:
    assert property (jd && qc == `BCFU_J_GT |-> res_o.taken ==
        (qf[`BCFU_CC_N] == qf[`BCFU_CC_V] && !qf[`BCFU_CC_Z])) else $error("gt jump wrong");
    a_hi_taken:
    assert property (jd && qc == `BCFU_J_HI |-> res_o.taken ==
        !(qf[`BCFU_CC_C] | qf[`BCFU_CC_Z])) else $error("hi jump wrong");
    a_cc_taken:
    assert property (jd && qc == `BCFU_J_CARRY0 |-> res_o.taken == !qf[`BCFU_CC_C])
        else $error("carry clear jump wrong");
    a_bit_flags:
    assert property (take && req_i.op == bcfu_pkg::OP_BITTEST |=> done_o
        && !res_o.cc[`BCFU_CC_V] && res_o.cc[`BCFU_CC_C] == $past(req_i.cc[`BCFU_CC_C])
        && res_o.cc[`BCFU_CC_Z] == ($past(and_res) == `BCFU_ZERO8) && !res_o.acc_we)
        else $error("bit test flags wrong");
    a_le_taken:
    assert property (jd && qc == `BCFU_J_LE |-> res_o.taken ==
        (qf[`BCFU_CC_Z] || (qf[`BCFU_CC_N] ^ qf[`BCFU_CC_V]))) else $error("le jump wrong");
    a_cs_taken:
    assert property (jd && qc == `BCFU_J_CARRY1 |-> res_o.taken == qf[`BCFU_CC_C])
        else $error("carry set jump wrong");
    a_ls_taken:
    assert property (jd && qc == `BCFU_J_LS |-> res_o.taken ==
        (qf[`BCFU_CC_C] | qf[`BCFU_CC_Z])) else $error("ls jump wrong");
    a_lt_taken:
    assert property (jd && qc == `BCFU_J_LT |-> res_o.taken ==
        (qf[`BCFU_CC_N] ^ qf[`BCFU_CC_V])) else $error("lt jump wrong");
    a_mi_taken:
    assert property (jd && qc == `BCFU_J_MINUS |-> res_o.taken == qf[`BCFU_CC_N])
        else $error("minus jump wrong");
    a_ne_taken:
    assert property (jd && qc == `BCFU_J_NE |-> res_o.taken == !qf[`BCFU_CC_Z])
        else $error("ne jump wrong");
    a_pl_taken:
    assert property (jd && qc == `BCFU_J_PLUS |-> res_o.taken == !qf[`BCFU_CC_N])
        else $error("plus jump wrong");
    a_pc_target:
    assert property (jd && res_o.taken |-> res_o.pc == tgt_held)
        else $error("jump target wrong");
    a_never_seq:
    assert property (jd && qc == `BCFU_J_NEVER |-> !res_o.taken && res_o.pc == s_reg.req.pc)
        else $error("never jump moved pc");
    a_push_hi:
    assert property (s_lo_ack |=> mem_o.valid && mem_o.we && mem_o.addr ==
        $past(mem_o.addr) - `BCFU_STEP && mem_o.wdata == s_reg.req.pc[15:8])
        else $error("call push order wrong");
    a_vc_taken:
    assert property (jd && qc == `BCFU_J_OVF0 |-> res_o.taken == !qf[`BCFU_CC_V])
        else $error("no overflow jump wrong");
    a_vs_taken:
    assert property (jd && qc == `BCFU_J_OVF1 |-> res_o.taken == qf[`BCFU_CC_V])
        else $error("overflow jump wrong");
    a_clr_flags:
    assert property (take && req_i.op == bcfu_pkg::OP_CLR_ACC |=> done_o
        && res_o.data == `BCFU_ZERO8 && res_o.acc_we && res_o.cc[`BCFU_CC_Z]
        && res_o.cc[`BCFU_CC_H] == $past(req_i.cc[`BCFU_CC_H])) else $error("clear wrong");
    a_clr_rdwr:
    assert property (s_clr_rd |=> mem_o.valid && mem_o.we && mem_o.wdata == `BCFU_ZERO8
        && mem_o.addr == $past(mem_o.addr)) else $error("clear write sequence wrong");
    a_cmp_nostore:
    assert property (take && req_i.op == bcfu_pkg::OP_CMP8 |=> done_o && !res_o.acc_we
        && !mem_o.valid) else $error("compare stored a result");
    a_cmp_borrow:
    assert property (take && req_i.op == bcfu_pkg::OP_CMP8 |=> res_o.cc[`BCFU_CC_C] ==
        ($past(req_i.acc[7:0]) < $past(req_i.mem[7:0]))) else $error("borrow wrong");
    a_cmp16_flags:
    assert property (take && req_i.op == bcfu_pkg::OP_CMP16 |=> res_o.cc[`BCFU_CC_C] ==
        ($past(req_i.acc) < $past(req_i.mem)) && res_o.cc[`BCFU_CC_H] ==
        $past(req_i.cc[`BCFU_CC_H])) else $error("16-bit compare wrong");
    a_flags_kept:
    assert property (jd |-> res_o.cc == qf) else $error("jump altered flags");

endmodule
`default_nettype wire

/* rtl/bcfu_regs.svh */
`ifndef BCFU_REGS_SVH
`define BCFU_REGS_SVH

// Condition code bit positions
`define BCFU_CC_C 0
`define BCFU_CC_V 1
`define BCFU_CC_Z 2
`define BCFU_CC_N 3
`define BCFU_CC_H 5

// Jump condition selector
`define BCFU_J_ALWAYS   4'h0
`define BCFU_J_NEVER    4'h1
`define BCFU_J_HI       4'h2
`define BCFU_J_LS       4'h3
`define BCFU_J_CARRY0   4'h4
`define BCFU_J_CARRY1   4'h5
`define BCFU_J_NE       4'h6
`define BCFU_J_EQ       4'h7
`define BCFU_J_OVF0     4'h8
`define BCFU_J_OVF1     4'h9
`define BCFU_J_PLUS     4'ha
`define BCFU_J_MINUS    4'hb
`define BCFU_J_GE       4'hc
`define BCFU_J_LT       4'hd
`define BCFU_J_GT       4'he
`define BCFU_J_LE       4'hf

// Register byte offsets
`define BCFU_OFS_CTRL   4'h0
`define BCFU_OFS_STATUS 4'h4
`define BCFU_OFS_COUNT  4'h8

// Field positions and reset values
`define BCFU_CTRL_EN     0
`define BCFU_CTRL_RST    1'b1
`define BCFU_ST_BUSY     0
`define BCFU_ST_TAKEN    1
`define BCFU_ST_CC_LSB   8
`define BCFU_ST_CC_MSB   15

// Constants
`define BCFU_ZERO8   8'h00
`define BCFU_STEP    16'h0001

`endif

/* rtl/bcfu_pkg.sv */
package bcfu_pkg;

    typedef enum logic [2:0] {
        OP_JUMP, OP_CALL, OP_BITTEST, OP_CLR_ACC, OP_CLR_MEM, OP_CMP8, OP_CMP16
    } bcfu_op_e;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CLR_RD, ST_CLR_WR, ST_PUSH_LO, ST_PUSH_HI
    } bcfu_state_e;

    typedef struct packed {
        bcfu_op_e    op;
        logic [3:0]  cond;
        logic        long_off;
        logic [15:0] acc;
        logic [15:0] mem;
        logic [15:0] offset;
        logic [7:0]  cc;
        logic [15:0] pc;
        logic [15:0] sp;
        logic [15:0] ea;
    } bcfu_req_s;

    typedef struct packed {
        logic [7:0]  cc;
        logic [15:0] pc;
        logic [15:0] sp;
        logic [7:0]  data;
        logic        acc_we;
        logic        taken;
    } bcfu_res_s;

    typedef struct packed {
        logic        valid;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } bcfu_mem_s;

    typedef struct packed {
        bcfu_state_e st;
        bcfu_req_s   req;
        bcfu_res_s   res;
        logic        done;
        bcfu_mem_s   mem;
        logic        en;
        logic [15:0] cnt;
        logic        ack;
        logic [31:0] dat;
    } bcfu_state_s;

endpackage

/* sim/bcfu_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module bcfu_mem_model (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                reset,
    // Access from the unit
    input  wire bcfu_pkg::bcfu_mem_s mem,
    input  wire logic [3:0]          dly,
    output logic                     ack
);
    logic [3:0]  wait_reg;
    logic [24:0] log_q[$];

    // Stall dly cycles, then one ack pulse
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset || ack || !mem.valid)
        begin
            wait_reg <= 4'h0;
            ack      <= 1'b0;
        end
        else if (wait_reg == dly)
            ack <= 1'b1;
        else
            wait_reg <= wait_reg + 4'h1;
    end

    // Record each access at its completing edge
    always @(posedge clk)
        if (!reset && ack && mem.valid)
            log_q.push_back({mem.we, mem.addr, mem.wdata});
endmodule
`default_nettype wire

/* sim/bcfu_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module bcfu_top_tb_top;
    logic                clk;
    logic                reset;
    logic                req_valid_i;
    bcfu_pkg::bcfu_req_s req_i;
    logic                req_ready_o;
    logic                done_o;
    bcfu_pkg::bcfu_res_s res_o;
    bcfu_pkg::bcfu_mem_s mem_o;
    logic                mem_ack_i;
    logic                wb_cyc_i;
    logic                wb_stb_i;
    logic                wb_we_i;
    logic [3:0]          wb_adr_i;
    logic [3:0]          wb_sel_i;
    logic [31:0]         wb_dat_i;
    logic [31:0]         wb_dat_o;
    logic                wb_ack_o;
    logic [3:0]          dly;
    logic [31:0]         rd;
    int                  bad_count;
    int                  total_checks;
    int                  ntaken;

    bcfu_top uut (
        .clk(clk), .reset(reset), .req_valid_i(req_valid_i), .req_i(req_i),
        .req_ready_o(req_ready_o), .done_o(done_o), .res_o(res_o), .mem_o(mem_o),
        .mem_ack_i(mem_ack_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
    );

    bcfu_mem_model mdl (.clk(clk), .reset(reset), .mem(mem_o), .dly(dly), .ack(mem_ack_i));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= dat;
        // Ack and data are taken at the edge that samples them
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        chk(32'(wb_ack_o), 32'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic run(input bcfu_pkg::bcfu_req_s r);
        int n;
        n = 0;
        @(posedge clk);
        req_valid_i <= 1'b1;
        req_i       <= r;
        #1;
        while (req_ready_o !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        req_valid_i <= 1'b0;
        #1;
        while (done_o !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(32'(done_o), 32'h1);
    endtask

    function automatic logic taken_exp(input logic [3:0] c, input logic [3:0] f);
        logic n, z, v, cy;
        logic [15:0] t;
        {n, z, v, cy} = f;
        t = {z | (n ^ v), !z & !(n ^ v), n ^ v, !(n ^ v), n, !n, v, !v,
             z, !z, cy, !cy, cy | z, !(cy | z), 1'b0, 1'b1};
        return t[c];
    endfunction

    task automatic t_reg_reset;
        wb(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h1);
        wb(1'b0, 4'h4, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 4'h8, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, 4'hc, 32'hffff_ffff);
        wb(1'b0, 4'hc, 32'h0);
        chk(rd, 32'h0);
    endtask

    task automatic t_jumps;
        bcfu_pkg::bcfu_req_s r;
        logic [15:0] off;
        logic [15:0] epc;
        logic tk;
        for (int c = 0; c < 16; c++)
            for (int f = 0; f < 16; f++)
            begin
                r = '0;
                r.op = bcfu_pkg::OP_JUMP;
                r.cond = c[3:0];
                r.long_off = c[0];
                r.offset = c[0] ? 16'h8123 : 16'h5af0;
                r.cc = {4'ha, f[3:0]};
                r.pc = 16'h1000;
                off = c[0] ? 16'h8123 : 16'hfff0;
                tk = taken_exp(c[3:0], f[3:0]);
                epc = tk ? 16'h1000 + off : 16'h1000;
                ntaken += int'(tk);
                run(r);
                chk(32'(res_o.taken), 32'(tk));
                chk(32'(res_o.pc), 32'(epc));
                chk(32'(res_o.cc), 32'(r.cc));
            end
    endtask

    task automatic t_reg_after;
        wb(1'b0, 4'h8, 32'h0);
        chk(rd, 32'(ntaken));
        wb(1'b0, 4'h4, 32'h0);
        chk(rd, 32'h0000_af02);
        wb(1'b1, 4'h8, 32'h0);
        wb(1'b0, 4'h8, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, 4'h0, 32'h0);
        @(posedge clk);
        chk(32'(req_ready_o), 32'h0);
        wb(1'b1, 4'h0, 32'h1);
        @(posedge clk);
        chk(32'(req_ready_o), 32'h1);
    endtask

    task automatic flag_op(input bcfu_pkg::bcfu_op_e op, input logic [15:0] a, input logic [15:0] b,
                           input logic [7:0] cc, input logic [7:0] ecc, input logic we);
        bcfu_pkg::bcfu_req_s r;
        r = '0;
        r.op = op;
        r.acc = a;
        r.mem = b;
        r.cc = cc;
        run(r);
        chk(32'(res_o.cc), 32'(ecc));
        chk(32'(res_o.acc_we), 32'(we));
        if (op == bcfu_pkg::OP_CLR_ACC)
            chk(32'(res_o.data), 32'h0);
    endtask

    task automatic t_flag_ops;
        flag_op(bcfu_pkg::OP_BITTEST, 16'h55f0, 16'h0081, 8'h23, 8'h29, 1'b0);
        flag_op(bcfu_pkg::OP_BITTEST, 16'h550f, 16'h00f0, 8'h2a, 8'h24, 1'b0);
        flag_op(bcfu_pkg::OP_CLR_ACC, 16'h1234, 16'h0, 8'hff, 8'hf4, 1'b1);
        flag_op(bcfu_pkg::OP_CLR_ACC, 16'h0080, 16'h0, 8'h09, 8'h04, 1'b1);
    endtask

    task automatic cmp(input logic w, input logic [15:0] a, input logic [15:0] b);
        logic [16:0] d;
        logic n, z, v, c;
        int k;
        k = w ? 15 : 7;
        d = w ? {1'b0, a} - {1'b0, b} : {9'h0, a[7:0]} - {9'h0, b[7:0]};
        n = d[k];
        z = w ? d[15:0] == 16'h0 : d[7:0] == 8'h0;
        v = (a[k] ^ b[k]) & (a[k] ^ d[k]);
        c = w ? d[16] : d[8];
        flag_op(w ? bcfu_pkg::OP_CMP16 : bcfu_pkg::OP_CMP8, w ? a : {8'h77, a[7:0]},
                w ? b : {8'h99, b[7:0]}, 8'h2f, {4'h2, n, z, v, c}, 1'b0);
    endtask

    task automatic t_cmp;
        cmp(1'b0, 16'h10, 16'h20);
        cmp(1'b0, 16'h80, 16'h01);
        cmp(1'b0, 16'h05, 16'h05);
        cmp(1'b0, 16'h7f, 16'hff);
        cmp(1'b1, 16'h8000, 16'h0001);
        cmp(1'b1, 16'h1234, 16'h1234);
        cmp(1'b1, 16'h0001, 16'h0002);
        cmp(1'b1, 16'h7fff, 16'hffff);
    endtask

    task automatic t_mem_ops;
        bcfu_pkg::bcfu_req_s r;
        r = '0;
        r.op = bcfu_pkg::OP_CLR_MEM;
        r.ea = 16'h4321;
        r.cc = 8'h2b;
        dly <= 4'h3;
        run(r);
        chk(32'(res_o.cc), 32'h24);
        chk(32'(mdl.log_q.size()), 32'h2);
        chk(32'(mdl.log_q[0][24:8]), 32'h04321);
        chk(32'(mdl.log_q[1]), {7'h0, 1'b1, 16'h4321, 8'h00});
        mdl.log_q.delete();
        r.op = bcfu_pkg::OP_CALL;
        r.pc = 16'h1234;
        r.sp = 16'h0200;
        r.offset = 16'h7710;
        r.cc = 8'h55;
        dly <= 4'h1;
        run(r);
        chk(32'(mdl.log_q.size()), 32'h2);
        chk(32'(mdl.log_q[0]), 32'h01_01ff_34);
        chk(32'(mdl.log_q[1]), 32'h01_01fe_12);
        chk({res_o.pc, res_o.sp}, 32'h1244_01fe);
        chk(32'({res_o.taken, res_o.cc}), 32'h155);
        chk(32'(mem_o.valid), 32'h0);
    endtask

    initial
    begin
        reset = 1'b1;
        req_valid_i = 1'b0;
        req_i = '0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 4'h0;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        dly = 4'h0;
        bad_count = 0;
        total_checks = 0;
        ntaken = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_reg_reset;
        t_jumps;
        t_reg_after;
        t_flag_ops;
        t_cmp;
        t_mem_ops;
        tally_and_finish;
    end

    // Cut a hang short
    initial
    begin
        #5000000;
        bad_count++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
